// file: hw/pmc_regs.svh
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// Functional notes
// - strap pair picks bypass, x6, x12; pattern 11 is reserved.
// - undriven straps read as 00, giving bypass with core clock equal reference.
// - 000000 runs; 001001 cpu stop, enabled irq; 010001 cpu stop, any irq.
// - 011010 stops pll output, 011100 stops pll input; reset-only wake.
// - cpu clock stop takes effect eight to nine cycles after the write.
// - wake by non-enabled irq resumes at stop point, no service routine.
// - wake by enabled irq runs service routine first, then resumes.
// - cpu clock gated at boundary; interrupt logic and transfer engine keep running.
// - pll output stop halts whole chip clock; contents kept.
// - pll input stop halts pll feed; after reset the pll re-locks first; lock wait here only with x6/x12 straps, none in bypass.
// - pll stop modes end only by device reset, never by interrupt.
// - in pll stop modes functional outputs hold last value.
// - gating acts only on reference-derived clocks, not other input clocks.
// - attached emulator masks user power-down until emulator reset or removed.
// - in pll stop modes emulator run or step spins idle; pc writes fail.
`define PMC_CSR_ADDR 12'h000
`define PMC_STAT_ADDR 12'h004
`define PMC_POWERDOWN_FIELD_LSB 10
`define PMC_POWERDOWN_FIELD_MSB 15
`define PMC_POWERDOWN_FIELD_RST 6'h00
`define PMC_CODE_RUN 6'h00
`define PMC_CODE_PD1E 6'h09
`define PMC_CODE_PD1A 6'h11
`define PMC_CODE_PD2 6'h1a
`define PMC_CODE_PD3 6'h1c
`define PMC_PD1_DELAY 4'h8
`define PMC_LOCK_US 75
`define PMC_LOCK_MARGIN_PCT 150
`define PMC_CLK_MHZ 25
`endif

// file: hw/pmc_pkg.sv
package pmc_pkg;
   typedef enum logic [2:0]
   {
      PMC_RUN = 3'b000,
      PMC_PD1_WAIT = 3'b001,
      PMC_PD1 = 3'b010,
      PMC_PD2 = 3'b011,
      PMC_PD3 = 3'b100,
      PMC_LOCK = 3'b101
   } pmc_state_e;
   typedef enum logic [1:0]
   {
      PMC_MULT_X1 = 2'b00,
      PMC_MULT_X6 = 2'b01,
      PMC_MULT_X12 = 2'b10,
      PMC_MULT_RSVD = 2'b11
   } pmc_mult_e;
   typedef struct packed
   {
      logic cpu_clk_en;
      logic chip_clk_en;
      logic pll_in_en;
      logic io_freeze;
      logic emu_spin;
   } pmc_gate_s;
endpackage : pmc_pkg

// file: hw/pmc_sync2.sv
`timescale 1ns/100ps
module pmc_sync2 #(parameter int W = 1)
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : pmc_sync2

// file: hw/pmc_lock_timer.sv
`timescale 1ns/100ps
module pmc_lock_timer #(parameter int CYCLES = 4688)
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // control
   input wire logic start,
   output logic busy
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   always_comb
   begin
      cnt_d = cnt_q;
      if (start)
         cnt_d = 16'(CYCLES);
      else if (cnt_q != 16'h0000)
         cnt_d = cnt_q - 16'h0001;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_d;
   end
   assign busy = (cnt_q != 16'h0000);
endmodule : pmc_lock_timer

// file: hw/pmc_top.sv
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "pmc_regs.svh"
module pmc_top #(
   parameter int LOCK_CYCLES = (`PMC_LOCK_US * `PMC_CLK_MHZ * (100 + `PMC_LOCK_MARGIN_PCT)) / 100
)
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // strap pins
   input wire logic pll_mult_select_hi,
   input wire logic pll_mult_select_lo,
   // interrupt and emulator status
   input wire logic irq_pending,
   input wire logic irq_enabled,
   input wire logic emu_attached,
   // clock control outputs
   output logic [1:0] pll_mult,
   output logic pll_bypass,
   output logic cpu_clk_en,
   output logic chip_clk_en,
   output logic pll_in_en,
   output logic io_freeze,
   output logic emu_spin,
   output logic isr_request,
   output logic clocks_valid
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [1:0] strap_s;
   logic emu_s;
   pmc_sync2 #(.W(2)) u_strap_sync
   (
      .clock(clock),
      .nrst(nrst),
      .din({pll_mult_select_hi, pll_mult_select_lo}),
      .dout(strap_s)
   );
   pmc_sync2 #(.W(1)) u_emu_sync
   (
      .clock(clock),
      .nrst(nrst),
      .din(emu_attached),
      .dout(emu_s)
   );

   // ************************************************************
   // strap capture after reset
   // ************************************************************
   logic [1:0] mult_q;
   logic [1:0] mult_d;
   logic [1:0] cap_q;
   logic [1:0] cap_d;
   logic lock_start;
   logic lock_busy;
   always_comb
   begin
      mult_d = mult_q;
      cap_d = cap_q;
      lock_start = 1'b0;
      if (cap_q != 2'h3)
         cap_d = cap_q + 2'h1;
      // strap decode, reserved maps to bypass
      if (cap_q == 2'h2)
      begin
         mult_d = (strap_s == pmc_pkg::PMC_MULT_RSVD) ? pmc_pkg::PMC_MULT_X1 : strap_s;
         // pll locks after every reset in multiply mode
         lock_start = (strap_s == pmc_pkg::PMC_MULT_X6) || (strap_s == pmc_pkg::PMC_MULT_X12);
      end
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         mult_q <= 2'h0;
         cap_q <= 2'h0;
      end
      else
      begin
         mult_q <= mult_d;
         cap_q <= cap_d;
      end
   end
   pmc_lock_timer #(.CYCLES(LOCK_CYCLES)) u_lock
   (
      .clock(clock),
      .nrst(nrst),
      .start(lock_start),
      .busy(lock_busy)
   );

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   logic ap_wr_q;
   logic ap_wr_d;
   logic ap_rd_q;
   logic ap_rd_d;
   logic [11:0] ap_addr_q;
   logic [11:0] ap_addr_d;
   logic [5:0] powerdown_field_q;
   logic [5:0] powerdown_field_d;
   logic powerdown_field_wr;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   pmc_pkg::pmc_state_e st_q;
   pmc_pkg::pmc_state_e st_d;
   always_comb
   begin
      ap_wr_d = 1'b0;
      ap_rd_d = 1'b0;
      ap_addr_d = ap_addr_q;
      powerdown_field_d = powerdown_field_q;
      powerdown_field_wr = 1'b0;
      rdata_d = 32'h0000_0000;
      if (hsel && hready && htrans[1])
      begin
         ap_wr_d = hwrite;
         ap_rd_d = !hwrite;
         ap_addr_d = haddr;
         if (!hwrite && haddr == `PMC_CSR_ADDR)
            rdata_d = {16'h0000, powerdown_field_q, 10'h000};
         else if (!hwrite && haddr == `PMC_STAT_ADDR)
            rdata_d = {23'h000000, lock_busy, emu_s, mult_q, st_q, 1'b0};
      end
      // whole field written at once, reserved bit kept zero
      if (ap_wr_q && ap_addr_q == `PMC_CSR_ADDR)
      begin
         powerdown_field_d = {1'b0, hwdata[`PMC_POWERDOWN_FIELD_MSB-1:`PMC_POWERDOWN_FIELD_LSB]};
         powerdown_field_wr = 1'b1;
      end
      // wake clears field so cpu resumes normally
      if (st_q == pmc_pkg::PMC_PD1 && st_d == pmc_pkg::PMC_RUN)
         powerdown_field_d = `PMC_POWERDOWN_FIELD_RST;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ap_wr_q <= 1'b0;
         ap_rd_q <= 1'b0;
         ap_addr_q <= 12'h000;
         powerdown_field_q <= `PMC_POWERDOWN_FIELD_RST;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ap_wr_q <= ap_wr_d;
         ap_rd_q <= ap_rd_d;
         ap_addr_q <= ap_addr_d;
         powerdown_field_q <= powerdown_field_d;
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // power-down state machine
   // ************************************************************
   logic [3:0] dly_q;
   logic [3:0] dly_d;
   logic isr_d;
   always_comb
   begin
      st_d = st_q;
      dly_d = dly_q;
      isr_d = 1'b0;
      case (st_q)
         pmc_pkg::PMC_RUN:
         begin
            if (powerdown_field_wr && !emu_s)
            begin
               case (hwdata[`PMC_POWERDOWN_FIELD_MSB:`PMC_POWERDOWN_FIELD_LSB])
                  `PMC_CODE_PD1E, `PMC_CODE_PD1A:
                  begin
                     st_d = pmc_pkg::PMC_PD1_WAIT;
                     dly_d = `PMC_PD1_DELAY - 4'h1;
                  end
                  `PMC_CODE_PD2: st_d = pmc_pkg::PMC_PD2;
                  `PMC_CODE_PD3: st_d = pmc_pkg::PMC_PD3;
                  default: st_d = pmc_pkg::PMC_RUN;
               endcase
            end
         end
         pmc_pkg::PMC_PD1_WAIT:
         begin
            // count to eight cycles after the write
            if (dly_q == 4'h0)
               st_d = pmc_pkg::PMC_PD1;
            else
               dly_d = dly_q - 4'h1;
         end
         pmc_pkg::PMC_PD1:
         begin
            if (emu_s)
               st_d = pmc_pkg::PMC_RUN;
            else if (irq_pending && irq_enabled)
            begin
               st_d = pmc_pkg::PMC_RUN;
               isr_d = 1'b1;
            end
            else if (irq_pending && powerdown_field_q == `PMC_CODE_PD1A)
               st_d = pmc_pkg::PMC_RUN;
         end
         // pll stop states left only by reset
         pmc_pkg::PMC_PD2: st_d = pmc_pkg::PMC_PD2;
         pmc_pkg::PMC_PD3: st_d = pmc_pkg::PMC_PD3;
         pmc_pkg::PMC_LOCK: st_d = pmc_pkg::PMC_RUN;
         default: st_d = pmc_pkg::PMC_RUN;
      endcase
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= pmc_pkg::PMC_RUN;
         dly_q <= 4'h0;
      end
      else
      begin
         st_q <= st_d;
         dly_q <= dly_d;
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   pmc_pkg::pmc_gate_s gate_d;
   pmc_pkg::pmc_gate_s gate_q;
   always_comb
   begin
      // only cpu boundary gated in cpu stop
      gate_d.cpu_clk_en = !(st_d == pmc_pkg::PMC_PD1 || st_d == pmc_pkg::PMC_PD2
                            || st_d == pmc_pkg::PMC_PD3);
      // pll output stop halts chip, io frozen
      gate_d.chip_clk_en = !(st_d == pmc_pkg::PMC_PD2 || st_d == pmc_pkg::PMC_PD3);
      gate_d.io_freeze = (st_d == pmc_pkg::PMC_PD2 || st_d == pmc_pkg::PMC_PD3);
      gate_d.pll_in_en = (st_d != pmc_pkg::PMC_PD3);
      gate_d.emu_spin = gate_d.io_freeze;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         gate_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
         isr_request <= 1'b0;
         clocks_valid <= 1'b0;
         pll_mult <= 2'h0;
         pll_bypass <= 1'b1;
      end
      else
      begin
         gate_q <= gate_d;
         isr_request <= isr_d;
         clocks_valid <= (cap_q == 2'h3) && !lock_busy && !lock_start;
         pll_mult <= mult_q;
         pll_bypass <= (mult_q == pmc_pkg::PMC_MULT_X1);
      end
   end
   assign cpu_clk_en = gate_q.cpu_clk_en;
   assign chip_clk_en = gate_q.chip_clk_en;
   assign pll_in_en = gate_q.pll_in_en;
   assign io_freeze = gate_q.io_freeze;
   assign emu_spin = gate_q.emu_spin;
   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ************************************************************
   // assertions
   // ************************************************************
   // stop follows write by eight cycles
   pd1_delay_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(st_q == pmc_pkg::PMC_PD1_WAIT) |-> ##8 (st_q == pmc_pkg::PMC_PD1))
      else $error("cpu stop not entered eight cycles after write");
   pll_stop_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_PD2) |=> (st_q == pmc_pkg::PMC_PD2))
      else $error("pll output stop left without reset");
   pd3_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_PD3) |=> !pll_in_en)
      else $error("pll input not stopped");
   cpu_gate_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_PD1) |-> (!cpu_clk_en && chip_clk_en))
      else $error("cpu stop gating wrong");
   chip_gate_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_PD2) |-> (!chip_clk_en && io_freeze && emu_spin))
      else $error("pll output stop gating wrong");
   emu_mask_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_RUN && emu_s) |=> (st_q == pmc_pkg::PMC_RUN))
      else $error("power-down entered with emulator attached");
   rsvd_code_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_RUN && powerdown_field_wr && !(hwdata[15:10] inside {`PMC_CODE_PD1E,
         `PMC_CODE_PD1A, `PMC_CODE_PD2, `PMC_CODE_PD3}))
      |=> (st_q == pmc_pkg::PMC_RUN))
      else $error("reserved code stopped clocks");
   isr_wake_a: assert property (@(posedge clock) disable iff (!nrst)
      (st_q == pmc_pkg::PMC_PD1 && irq_pending && irq_enabled && !emu_s)
      |=> (isr_request && cpu_clk_en))
      else $error("enabled wake did not request service routine");
   pd1_cov_c: cover property (@(posedge clock) disable iff (!nrst)
      st_q == pmc_pkg::PMC_PD1 ##1 st_q == pmc_pkg::PMC_RUN);
   pd2_cov_c: cover property (@(posedge clock) disable iff (!nrst)
      st_q == pmc_pkg::PMC_PD2);
   pd3_cov_c: cover property (@(posedge clock) disable iff (!nrst)
      st_q == pmc_pkg::PMC_PD3);
endmodule : pmc_top

// file: bench/pmc_core_model.sv
`timescale 1ns/100ps
// ********************
// core and irq model
// ********************
module pmc_core_model
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // bench commands
   input wire logic raise,
   input wire logic raise_en,
   input wire logic drop,
   // from block
   input wire logic isr_request,
   // interrupt status
   output logic irq_pending,
   output logic irq_enabled
);
   logic pend_q;
   logic pend_d;
   always_comb
   begin
      pend_d = pend_q;
      if (raise)
         pend_d = 1'b1;
      if (isr_request || drop)
         pend_d = 1'b0;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         pend_q <= 1'b0;
      else
         pend_q <= pend_d;
   end
   assign irq_pending = pend_q;
   assign irq_enabled = raise_en;
endmodule : pmc_core_model

// file: bench/pmc_top_bench.sv
`timescale 1ns/100ps
// ********************
// bench top
// ********************
module pmc_top_bench;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] strap = 2'h0;
   logic raise = 1'b0;
   logic raise_en = 1'b0;
   logic drop = 1'b0;
   logic emu = 1'b0;
   logic hreadyout, hresp, irq_pending, irq_enabled;
   logic [31:0] hrdata;
   logic [31:0] d;
   logic [1:0] pll_mult;
   logic pll_bypass, cpu_clk_en, chip_clk_en, pll_in_en;
   logic io_freeze, emu_spin, isr_request, clocks_valid, isr_seen;
   int fails = 0;
   int checks = 0;
   int wait_n;
   always #20 clock = ~clock;
   pmc_top #(.LOCK_CYCLES(20)) pmc_top_inst (.clock(clock), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pll_mult_select_hi(strap[1]), .pll_mult_select_lo(strap[0]),
      .irq_pending(irq_pending), .irq_enabled(irq_enabled), .emu_attached(emu),
      .pll_mult(pll_mult), .pll_bypass(pll_bypass), .cpu_clk_en(cpu_clk_en),
      .chip_clk_en(chip_clk_en), .pll_in_en(pll_in_en), .io_freeze(io_freeze),
      .emu_spin(emu_spin), .isr_request(isr_request), .clocks_valid(clocks_valid));
   pmc_core_model pmc_core_model_inst (.clock(clock), .nrst(nrst), .raise(raise),
      .raise_en(raise_en), .drop(drop), .isr_request(isr_request),
      .irq_pending(irq_pending), .irq_enabled(irq_enabled));
   task report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wait_ready;
      int i;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clock);
         if (hreadyout === 1'b1)
            break;
      end
      if (i == 50)
      begin
         fails++;
         report_and_stop;
      end
   endtask : wait_ready
   task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      d = hrdata;
   endtask : bus
   // sel 0 watches cpu clock enable, 1 clocks valid
   task wait_on(input int sel, input logic tgt, input int lim);
      int i;
      isr_seen = 1'b0;
      for (i = 0; i < lim; i++)
      begin
         @(posedge clock);
         #1;
         if (isr_request === 1'b1)
            isr_seen = 1'b1;
         if ((sel == 0 ? cpu_clk_en : clocks_valid) === tgt)
            break;
      end
      wait_n = i + 1;
      if (i == lim)
      begin
         fails++;
         report_and_stop;
      end
   endtask : wait_on
   task pulse_irq;
      @(posedge clock);
      raise <= 1'b1;
      @(posedge clock);
      raise <= 1'b0;
   endtask : pulse_irq
   task reset_dut;
      nrst <= 1'b0;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
   endtask : reset_dut
   // ********************
   // scenarios
   // ********************
   task t_regs;
      chk(pll_bypass, 1);
      chk(pll_mult, 0);
      bus(1'b0, 12'h000, 32'h0);
      chk(d, 32'h0);
      bus(1'b0, 12'h010, 32'h0);
      chk(d, 32'h0);
      chk(hresp, 0);
   endtask : t_regs
   task t_pd1(input logic [31:0] code, input logic any);
      bus(1'b1, 12'h000, code);
      wait_on(0, 1'b0, 20);
      chk(wait_n >= 8 && wait_n <= 9, 1);
      chk({chip_clk_en, pll_in_en}, 2'b11);
      bus(1'b0, 12'h004, 32'h0);
      chk(d, 32'h4);
      pulse_irq;
      if (!any)
      begin
         repeat (10) @(posedge clock);
         chk(cpu_clk_en, 0);
         raise_en <= 1'b1;
      end
      wait_on(0, 1'b1, 20);
      chk(isr_seen, !any);
      raise_en <= 1'b0;
      drop <= 1'b1;
      bus(1'b0, 12'h000, 32'h0);
      drop <= 1'b0;
      chk(d, 32'h0);
   endtask : t_pd1
   task t_rsvd;
      bus(1'b1, 12'h000, 32'h0c00);
      repeat (12) @(posedge clock);
      chk({cpu_clk_en, chip_clk_en, pll_in_en}, 3'b111);
   endtask : t_rsvd
   task t_emu;
      emu <= 1'b1;
      repeat (4) @(posedge clock);
      bus(1'b1, 12'h000, 32'h6800);
      repeat (12) @(posedge clock);
      chk({cpu_clk_en, chip_clk_en, emu_spin}, 3'b110);
      bus(1'b1, 12'h000, 32'h0);
      emu <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : t_emu
   task t_strap;
      logic [1:0] pat[4] = '{2'h3, 2'h0, 2'h1, 2'h2};
      logic [2:0] exp[4] = '{3'h4, 3'h4, 3'h1, 3'h2};
      for (int i = 0; i < 4; i++)
      begin
         strap <= pat[i];
         reset_dut;
         wait_on(1, 1'b1, 200);
         chk(pll_mult, exp[i][1:0]);
         chk(pll_bypass, exp[i][2]);
      end
   endtask : t_strap
   task t_pllstop(input logic [31:0] code, input logic in_stop);
      bus(1'b1, 12'h000, code);
      repeat (12) @(posedge clock);
      chk({in_stop ? pll_in_en : chip_clk_en, io_freeze, emu_spin}, 3'b011);
      chk(pll_mult, 2'h2);
      raise_en <= 1'b1;
      pulse_irq;
      repeat (20) @(posedge clock);
      chk({in_stop ? pll_in_en : chip_clk_en, io_freeze}, 2'b01);
      raise_en <= 1'b0;
      reset_dut;
      @(posedge clock);
      chk(clocks_valid, 0);
      wait_on(1, 1'b1, 200);
      chk({chip_clk_en, pll_in_en, io_freeze}, 3'b110);
   endtask : t_pllstop
   initial
   begin
      reset_dut;
      repeat (4) @(posedge clock);
      t_regs;
      t_pd1(32'h2400, 1'b0);
      t_pd1(32'h4400, 1'b1);
      t_rsvd;
      t_emu;
      t_strap;
      t_pllstop(32'h6800, 1'b0);
      t_pllstop(32'h7000, 1'b1);
      report_and_stop;
   end
endmodule : pmc_top_bench
